// File: design/acc_top.sv
// Accelerometer target on the serial bus with its register file, plus the shared-bus owner mux.
`timescale 1ns/100ps
`include "acc_defs.svh"
// Summary of operation
// - The sensor answers only target address 0x53, seven bits wide.
// - Burst reads return successive registers from the set index.
// - Samples resolve up to 13 bits over plus or minus 16g.
// - Axis bytes sit at 0x32 to 0x37, low byte at lower index.
// - After reset the shared bus belongs to the logic side.
// - Select high hands the shared bus to the processor-side controller.
// - Direction bit one makes the pin an output, zero an input.
module acc_top
	import acc_pkg::*;
#(
	parameter logic [7:0] IDENT_VALUE = 8'h5a // Arbitrary identity value.
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic SNS_SCL_I,
	input wire logic SNS_SDA_I,
	output logic SNS_SDA_O,
	output logic SNS_SDA_OE_O,
	input wire logic [12:0] SAMPLE_X_I,
	input wire logic [12:0] SAMPLE_Y_I,
	input wire logic [12:0] SAMPLE_Z_I,
	input wire logic SAMPLE_VALID_I,
	output logic [7:0] OUTPUT_FORMAT_CFG_O,
	input wire logic [31:0] PORT_DIR_I,
	input wire logic [31:0] PORT_DATA_I,
	input wire logic PS_SCL_OE_I,
	input wire logic PS_SDA_OE_I,
	input wire logic PL_SCL_OE_I,
	input wire logic PL_SDA_OE_I,
	input wire logic BOARD_SCL_I,
	input wire logic BOARD_SDA_I,
	output logic BOARD_SCL_O,
	output logic BOARD_SCL_OE_O,
	output logic BOARD_SDA_O,
	output logic BOARD_SDA_OE_O,
	output logic PS_SCL_O,
	output logic PS_SDA_O,
	output logic PL_SCL_O,
	output logic PL_SDA_O,
	output logic OWNER_PS_O
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic scl_f;
	logic sda_f;
	logic bscl_f;
	logic bsda_f;
	acc_sync u_sync_scl (.clk_i(CLK_I), .reset_i(RESET_I), .pin_i(SNS_SCL_I), .level_o(scl_f));
	acc_sync u_sync_sda (.clk_i(CLK_I), .reset_i(RESET_I), .pin_i(SNS_SDA_I), .level_o(sda_f));
	acc_sync u_sync_bscl (.clk_i(CLK_I), .reset_i(RESET_I), .pin_i(BOARD_SCL_I), .level_o(bscl_f));
	acc_sync u_sync_bsda (.clk_i(CLK_I), .reset_i(RESET_I), .pin_i(BOARD_SDA_I), .level_o(bsda_f));
	// ----------------------------------------------------------------
	// Line events
	// ----------------------------------------------------------------
	logic scl_prev_q;
	logic sda_prev_q;
	wire scl_rise = scl_f & ~scl_prev_q;
	wire scl_fall = ~scl_f & scl_prev_q;
	wire start_seen = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire stop_seen = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
	// ----------------------------------------------------------------
	// Sample formatting
	// ----------------------------------------------------------------
	logic [7:0] fmt_q;
	logic [15:0] shadow_x_q;
	logic [15:0] shadow_y_q;
	logic [15:0] shadow_z_q;
	logic [15:0] live_x;
	logic [15:0] live_y;
	logic [15:0] live_z;
	wire full_res = fmt_q[`ACC_FMT_FULL_RES_BIT];
	wire left_just = fmt_q[`ACC_FMT_LEFT_JUST_BIT];
	wire [1:0] range_sel = fmt_q[`ACC_FMT_RANGE_MSB:`ACC_FMT_RANGE_LSB];
	// Full resolution widens with range, up to 13 bits at 16g; otherwise 10 bits.
	wire [4:0] res_bits = full_res ? (`ACC_BASE_RES_BITS + {3'h0, range_sel})
		: `ACC_BASE_RES_BITS;
	wire [4:0] left_shift = 5'h10 - res_bits;
	function automatic logic [15:0] acc_format(input logic [12:0] raw, input logic full,
		input logic left, input logic [1:0] rng, input logic [4:0] lsh);
		logic [15:0] ext;
		logic [15:0] scaled;
		ext = {{3{raw[12]}}, raw};
		scaled = full ? ext : 16'($signed(ext) >>> rng);
		acc_format = left ? 16'(scaled << lsh) : scaled;
	endfunction
	assign live_x = acc_format(SAMPLE_X_I, full_res, left_just, range_sel, left_shift);
	assign live_y = acc_format(SAMPLE_Y_I, full_res, left_just, range_sel, left_shift);
	assign live_z = acc_format(SAMPLE_Z_I, full_res, left_just, range_sel, left_shift);
	// ----------------------------------------------------------------
	// Target state machine
	// ----------------------------------------------------------------
	acc_state_t state_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [3:0] cnt_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic first_q;
	logic oe_q;
	logic zero_q;
	// Reading keeps the shadow frozen, so a burst sees one coherent sample set.
	// The address acknowledge of a read counts too, since the first byte is loaded at its end.
	wire reading = (state_q == ACC_RD) | (state_q == ACC_ACKR) | ((state_q == ACC_ACKA) & rw_q);
	wire addr_hit = (shift_q[7:1] == `ACC_TARGET_ADDR);
	wire wr_fmt = (ptr_q == `ACC_IDX_OUTPUT_FORMAT_CFG);
	wire [7:0] rd_byte =
		(ptr_q == `ACC_IDX_IDENT) ? IDENT_VALUE :
		(ptr_q == `ACC_IDX_OUTPUT_FORMAT_CFG) ? fmt_q :
		(ptr_q == `ACC_IDX_X_AXIS_LOW_BYTE) ? shadow_x_q[7:0] :
		(ptr_q == `ACC_IDX_X_AXIS_HIGH_BYTE) ? shadow_x_q[15:8] :
		(ptr_q == `ACC_IDX_Y_AXIS_LOW_BYTE) ? shadow_y_q[7:0] :
		(ptr_q == `ACC_IDX_Y_AXIS_HIGH_BYTE) ? shadow_y_q[15:8] :
		(ptr_q == `ACC_IDX_Z_AXIS_LOW_BYTE) ? shadow_z_q[7:0] :
		(ptr_q == `ACC_IDX_Z_AXIS_HIGH_BYTE) ? shadow_z_q[15:8] : 8'h00;
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			shadow_x_q <= 16'h0000;
			shadow_y_q <= 16'h0000;
			shadow_z_q <= 16'h0000;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
			if (SAMPLE_VALID_I && !reading) begin
				shadow_x_q <= live_x;
				shadow_y_q <= live_y;
				shadow_z_q <= live_z;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state_q <= ACC_IDLE;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			cnt_q <= 4'h0;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			oe_q <= 1'b0;
			fmt_q <= `ACC_FMT_RESET;
		end else if (start_seen) begin
			state_q <= ACC_ADDR;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else if (stop_seen) begin
			state_q <= ACC_IDLE;
			oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				ACC_IDLE: begin
				end
				ACC_ADDR, ACC_WR: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_f};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == ACC_ADDR) begin
							rw_q <= shift_q[0];
							oe_q <= addr_hit;
							state_q <= addr_hit ? ACC_ACKA : ACC_IDLE;
						end else begin
							oe_q <= 1'b1;
							state_q <= ACC_ACKW;
							first_q <= 1'b0;
							if (first_q) begin
								ptr_q <= shift_q;
							end else begin
								ptr_q <= ptr_q + 8'h01;
								if (wr_fmt) begin
									fmt_q <= shift_q;
								end
							end
						end
					end
				end
				ACC_ACKA: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							tx_q <= rd_byte;
							oe_q <= ~rd_byte[7];
							ptr_q <= ptr_q + 8'h01;
							state_q <= ACC_RD;
						end else begin
							oe_q <= 1'b0;
							first_q <= 1'b1;
							state_q <= ACC_WR;
						end
					end
				end
				ACC_ACKW: begin
					if (scl_fall) begin
						oe_q <= 1'b0;
						cnt_q <= 4'h0;
						state_q <= ACC_WR;
					end
				end
				ACC_RD: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							oe_q <= 1'b0;
							state_q <= ACC_ACKR;
						end else begin
							tx_q <= {tx_q[6:0], 1'b1};
							oe_q <= ~tx_q[6];
						end
					end
				end
				ACC_ACKR: begin
					// A missing acknowledge ends the burst; wait for stop.
					if (scl_rise) begin
						rw_q <= ~sda_f;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							tx_q <= rd_byte;
							oe_q <= ~rd_byte[7];
							ptr_q <= ptr_q + 8'h01;
							state_q <= ACC_RD;
						end else begin
							state_q <= ACC_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shared bus owner mux
	// ----------------------------------------------------------------
	// A port bit drives the select only when its direction bit marks it output.
	wire sel_out = PORT_DIR_I[`ACC_OWNER_SEL_BIT];
	wire owner_ps = sel_out & PORT_DATA_I[`ACC_OWNER_SEL_BIT];
	logic owner_q;
	logic bscl_oe_q;
	logic bsda_oe_q;
	logic ps_scl_q;
	logic ps_sda_q;
	logic pl_scl_q;
	logic pl_sda_q;
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			zero_q <= 1'b0;
			owner_q <= 1'b0;
			bscl_oe_q <= 1'b0;
			bsda_oe_q <= 1'b0;
			ps_scl_q <= 1'b1;
			ps_sda_q <= 1'b1;
			pl_scl_q <= 1'b1;
			pl_sda_q <= 1'b1;
		end else begin
			zero_q <= 1'b0;
			owner_q <= owner_ps;
			bscl_oe_q <= owner_q ? PS_SCL_OE_I : PL_SCL_OE_I;
			bsda_oe_q <= owner_q ? PS_SDA_OE_I : PL_SDA_OE_I;
			ps_scl_q <= owner_q ? bscl_f : 1'b1;
			ps_sda_q <= owner_q ? bsda_f : 1'b1;
			pl_scl_q <= owner_q ? 1'b1 : bscl_f;
			pl_sda_q <= owner_q ? 1'b1 : bsda_f;
		end
	end

	assign SNS_SDA_O = zero_q;
	assign SNS_SDA_OE_O = oe_q;
	assign OUTPUT_FORMAT_CFG_O = fmt_q;
	assign BOARD_SCL_O = zero_q;
	assign BOARD_SDA_O = zero_q;
	assign BOARD_SCL_OE_O = bscl_oe_q;
	assign BOARD_SDA_OE_O = bsda_oe_q;
	assign PS_SCL_O = ps_scl_q;
	assign PS_SDA_O = ps_sda_q;
	assign PL_SCL_O = pl_scl_q;
	assign PL_SDA_O = pl_sda_q;
	assign OWNER_PS_O = owner_q;
endmodule // acc_top

// File: design/acc_defs.svh
// Register offsets, field positions, reset values and addresses for the accelerometer reader.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ----------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------
`define ACC_TARGET_ADDR 7'h53
`define ACC_DECODER_ADDR 7'h20

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ACC_IDX_IDENT 8'h00
`define ACC_IDX_OUTPUT_FORMAT_CFG 8'h31
`define ACC_IDX_X_AXIS_LOW_BYTE 8'h32
`define ACC_IDX_X_AXIS_HIGH_BYTE 8'h33
`define ACC_IDX_Y_AXIS_LOW_BYTE 8'h34
`define ACC_IDX_Y_AXIS_HIGH_BYTE 8'h35
`define ACC_IDX_Z_AXIS_LOW_BYTE 8'h36
`define ACC_IDX_Z_AXIS_HIGH_BYTE 8'h37

// ----------------------------------------------------------------
// Output format fields and reset value
// ----------------------------------------------------------------
`define ACC_FMT_FULL_RES_BIT 3
`define ACC_FMT_LEFT_JUST_BIT 2
`define ACC_FMT_RANGE_MSB 1
`define ACC_FMT_RANGE_LSB 0
`define ACC_FMT_RESET 8'h00
`define ACC_BASE_RES_BITS 5'h0a

// ----------------------------------------------------------------
// Owner select port bit
// ----------------------------------------------------------------
`define ACC_OWNER_SEL_BIT 19
`define ACC_OWNER_SEL_MASK 32'h0008_0000

`endif

// File: design/acc_pkg.sv
// Types shared by the accelerometer reader design.
package acc_pkg;

	typedef enum logic [6:0] {
		ACC_IDLE = 7'b000_0001,
		ACC_ADDR = 7'b000_0010,
		ACC_ACKA = 7'b000_0100,
		ACC_WR = 7'b000_1000,
		ACC_ACKW = 7'b001_0000,
		ACC_RD = 7'b010_0000,
		ACC_ACKR = 7'b100_0000
	} acc_state_t;

endpackage

// File: design/acc_sync.sv
// Three-stage pin synchroniser that follows the input once stages two and three agree.
`timescale 1ns/100ps
module acc_sync (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Idle level of an open-drain line is high, so reset to one.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule // acc_sync

// File: dv/acc_properties.sv
// Concurrent checks on the ports of the accelerometer reader top.
`timescale 1ns/100ps
module acc_properties (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic SNS_SCL_I,
	input wire logic SNS_SDA_O,
	input wire logic SNS_SDA_OE_O,
	input wire logic [31:0] PORT_DIR_I,
	input wire logic [31:0] PORT_DATA_I,
	input wire logic PS_SDA_OE_I,
	input wire logic PL_SCL_OE_I,
	input wire logic PL_SDA_OE_I,
	input wire logic BOARD_SCL_O,
	input wire logic BOARD_SCL_OE_O,
	input wire logic BOARD_SDA_O,
	input wire logic BOARD_SDA_OE_O,
	input wire logic PS_SCL_O,
	input wire logic PS_SDA_O,
	input wire logic OWNER_PS_O,
	input wire logic [7:0] OUTPUT_FORMAT_CFG_O
);
	wire sel = PORT_DIR_I[19] & PORT_DATA_I[19];
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RESET_I);
	a_owner_set: assert property (sel |=> OWNER_PS_O)
		else $error("owner not taken");
	a_owner_clr: assert property (!sel |=> !OWNER_PS_O)
		else $error("owner kept");
	a_ps_route: assert property ((OWNER_PS_O && PS_SDA_OE_I) [*2] |=> BOARD_SDA_OE_O)
		else $error("ps data not routed");
	a_pl_route: assert property ((!OWNER_PS_O && PL_SCL_OE_I) [*2] |=> BOARD_SCL_OE_O)
		else $error("pl clock not routed");
	a_ps_blocked: assert property ((!OWNER_PS_O && !PL_SDA_OE_I) [*2] |=> !BOARD_SDA_OE_O)
		else $error("board data pulled");
	a_ps_idle: assert property (!OWNER_PS_O [*2] |=> PS_SCL_O && PS_SDA_O)
		else $error("ps side sees bus");
	a_open_drain: assert property (!SNS_SDA_O && !BOARD_SDA_O && !BOARD_SCL_O)
		else $error("line driven high");
	a_data_low_clk: assert property ($changed(SNS_SDA_OE_O) |-> !SNS_SCL_I)
		else $error("data moved with clock high");
	c_owner: cover property (sel ##1 OWNER_PS_O);
	c_ack: cover property ($rose(SNS_SDA_OE_O));
	c_fmt: cover property ($changed(OUTPUT_FORMAT_CFG_O));
endmodule // acc_properties

bind acc_top acc_properties u_props (
	.CLK_I, .RESET_I, .SNS_SCL_I, .SNS_SDA_O, .SNS_SDA_OE_O, .PORT_DIR_I, .PORT_DATA_I,
	.PS_SDA_OE_I, .PL_SCL_OE_I, .PL_SDA_OE_I, .BOARD_SCL_O, .BOARD_SCL_OE_O, .BOARD_SDA_O,
	.BOARD_SDA_OE_O, .PS_SCL_O, .PS_SDA_O, .OWNER_PS_O, .OUTPUT_FORMAT_CFG_O
);

// File: dv/acc_master_model.sv
// Behavioural serial-bus master that drives the sensor clock and data pins.
`timescale 1ns/100ps
module acc_master_model #(
	parameter int Q = 12
) (
	input wire logic clk_i,
	input wire logic sda_oe_i,
	output logic scl_o,
	output logic sda_o
);
	logic sda_q = 1'b1;
	initial scl_o = 1'b1;
	// The line has a pull-up, so it reads high unless a party pulls it low.
	assign sda_o = sda_q & ~sda_oe_i;
	// Only the serial pins are modelled, as the sensor's select strap stays high.
	task automatic step(input logic c, input logic s);
		scl_o = c;
		sda_q = s;
		repeat (Q) @(negedge clk_i);
	endtask
	// The clock keeps its level here, so no stray pulse appears outside a frame.
	task automatic start();
		step(scl_o, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, b);
		step(1'b1, b);
		r = sda_o;
		step(1'b1, b);
		step(1'b0, b);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // acc_master_model

// File: dv/accel_i2c_reader_with_bus_mux_test.sv
// Self-checking bench for the accelerometer reader and bus owner mux.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module accel_i2c_reader_with_bus_mux_test;
	logic clk, rst, sv, ack, sda, scl, sda_oe, own, bsc, bsd, ps_c, ps_d, pl_c, pl_d;
	logic ps_lc, ps_ld, pl_lc, pl_ld;
	logic [12:0] sx, sy, sz;
	logic [31:0] pdir, pdat;
	logic [7:0] fmt, d;
	int n_errors, checked, cyc;
	acc_master_model m (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
	acc_top uut (.CLK_I(clk), .RESET_I(rst), .SNS_SCL_I(scl), .SNS_SDA_I(sda), .SNS_SDA_O(),
		.SNS_SDA_OE_O(sda_oe), .SAMPLE_X_I(sx), .SAMPLE_Y_I(sy), .SAMPLE_Z_I(sz),
		.SAMPLE_VALID_I(sv), .OUTPUT_FORMAT_CFG_O(fmt), .PORT_DIR_I(pdir), .PORT_DATA_I(pdat),
		.PS_SCL_OE_I(ps_c), .PS_SDA_OE_I(ps_d), .PL_SCL_OE_I(pl_c), .PL_SDA_OE_I(pl_d),
		.BOARD_SCL_I(!bsc), .BOARD_SDA_I(!bsd), .BOARD_SCL_O(), .BOARD_SCL_OE_O(bsc),
		.BOARD_SDA_O(), .BOARD_SDA_OE_O(bsd), .PS_SCL_O(ps_lc), .PS_SDA_O(ps_ld),
		.PL_SCL_O(pl_lc), .PL_SDA_O(pl_ld), .OWNER_PS_O(own));
	task automatic report_and_stop();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic set_index(input logic [7:0] idx);
		m.start();
		m.wr_byte(8'hA6, ack);
		`CHK(ack, 1'b1)
		m.wr_byte(idx, ack);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_foreign();
		for (int i = 0; i < 2; i++) begin
			m.start();
			m.wr_byte(i ? 8'hA4 : 8'h40, ack);
			m.stop();
			`CHK(ack, 1'b0)
		end
	endtask
	// The second data byte lands on a read-only axis byte and must be dropped.
	task automatic t_format();
		set_index(8'h31);
		m.wr_byte(8'h0F, ack);
		m.wr_byte(8'h55, ack);
		`CHK(ack, 1'b1)
		m.stop();
		`CHK(fmt, 8'h0F)
		set_index(8'h31);
		m.start();
		m.wr_byte(8'hA7, ack);
		m.rd_byte(1'b1, d);
		m.stop();
		`CHK(d, 8'h0F)
	endtask
	task automatic t_burst();
		logic [12:0] s [3];
		logic [15:0] w;
		s = '{13'h0123, 13'h1F00, 13'h0FFF};
		{sx, sy, sz} = {s[0], s[1], s[2]};
		sv = 1'b1;
		@(negedge clk);
		sv = 1'b0;
		set_index(8'h32);
		m.start();
		m.wr_byte(8'hA7, ack);
		for (int i = 0; i < 6; i++) begin
			m.rd_byte(i == 5, d);
			w = {{3{s[i/2][12]}}, s[i/2]} << 3;
			`CHK(d, w[8*(i%2)+:8])
		end
		m.stop();
	endtask
	task automatic t_mux();
		pdat = 32'h0008_0000;
		ps_d = 1'b1;
		pl_c = 1'b1;
		// Board levels need the synchroniser delay before the logic side sees them.
		repeat (8) @(negedge clk);
		`CHK(own, 1'b0)
		`CHK({bsc, bsd}, 2'b10)
		`CHK({pl_lc, pl_ld, ps_lc, ps_ld}, 4'h7)
		pdir = 32'h0008_0000;
		@(negedge clk);
		`CHK(own, 1'b1)
		@(negedge clk);
		`CHK({bsc, bsd}, 2'b01)
		`CHK({pl_lc, pl_ld, ps_lc, ps_ld}, 4'hd)
		pdat = 32'h0000_0000;
		repeat (3) @(negedge clk);
		`CHK({own, bsc, bsd}, 3'b010)
		`CHK({ps_lc, ps_ld}, 2'b11)
		{ps_d, pl_c} = 2'b00;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		rst = 1'b1;
		{sv, sx, sy, sz, pdir, pdat, ps_c, ps_d, pl_c, pl_d} = '0;
		repeat (8) @(negedge clk);
		`CHK({own, fmt, sda_oe}, 10'h000)
		rst = 1'b0;
		repeat (8) @(negedge clk);
		t_foreign();
		t_format();
		t_burst();
		t_mux();
		report_and_stop();
	end
endmodule // accel_i2c_reader_with_bus_mux_test
